// File: rtl/fid_pkg.sv
// feature identification register bank: shared constants and types
package fid_pkg;

	// byte offsets on the register bus
	localparam logic [7:0] OFS_PRESETS_SIZES = 8'h04;
	localparam logic [7:0] OFS_VIRTUAL_TRANSLATION_PAGE_BASE = 8'h08;
	localparam logic [7:0] OFS_EXTENSIONS = 8'h0c;
	localparam logic [7:0] OFS_IMPL_DEFINED = 8'h10;
	localparam logic [7:0] OFS_GRANULE_ADDR = 8'h14;
	localparam logic [7:0] OFS_VIRTUAL_TRANSLATION_PAGE_PAGE = 8'h18;
	localparam logic [7:0] OFS_QUEUE_CFG = 8'h20;
	localparam logic [7:0] OFS_IDX_BASE = 8'h30;
	localparam logic [7:0] OFS_IDX_STRIDE = 8'h08;
	localparam logic [7:0] OFS_CONS_STEP = 8'h04;
	localparam logic [7:0] OFS_QUEUE_STAT = 8'h50;
	localparam logic [7:0] OFS_WR_IGNORED = 8'h54;

	// limits and encodings
	localparam logic [4:0] QS_MAX = 5'h13;
	localparam logic [4:0] SSID_MAX = 5'h14;
	localparam logic [5:0] SID_MAX = 6'h20;
	localparam logic [1:0] BREAK_MAKE_LEVEL_L1 = 2'h1;
	localparam logic [1:0] BREAK_MAKE_LEVEL_L2 = 2'h2;
	localparam logic [1:0] VAX_48 = 2'h0;
	localparam logic [1:0] VAX_52 = 2'h1;
	localparam logic [2:0] OAS_48 = 3'h5;
	localparam logic [2:0] OAS_52 = 3'h6;
	localparam logic [2:0] OAS_RSVD = 3'h7;
	localparam logic [31:0] VIRTUAL_TRANSLATION_PAGE_PAGE_ORIGIN = 32'h0002_0000;
	localparam logic [31:0] VIRTUAL_TRANSLATION_PAGE_PAGE_UNIT = 32'h0001_0000;
	localparam int unsigned NUM_QUEUES = 3;
	localparam int unsigned IDX_W = 20;
	localparam logic [31:0] QUEUE_CFG_RST = 32'h0000_0000;
	localparam logic [IDX_W-1:0] IDX_RST = 20'h0_0000;
	localparam logic [15:0] WR_IGNORED_RST = 16'h0000;
	localparam logic [1:0] RSP_OKAY = 2'h0;
	localparam logic [1:0] RSP_DECODEERROR = 2'h3;

	// raw capabilities of one build
	typedef struct packed {
		logic tables_preset;
		logic queues_preset;
		logic offset_style_base_flag;
		logic memtype_override_support;
		logic permission_override_support;
		logic [4:0] command_queue_max_log2;
		logic [4:0] event_queue_max_log2;
		logic [4:0] page_request_queue_max_log2;
		logic [4:0] substream_id_width;
		logic [5:0] stream_id_width;
		logic virtual_translation_page_present;
		logic page_req_present;
		logic stage1_present;
		logic fmt32_present;
		logic [9:0] virtual_translation_page_base;
		logic [1:0] break_make_level;
		logic range_invalidation_support;
		logic small_table_support;
		logic stage2_memtype_control;
		logic partitioning_monitoring_support;
		logic overflow_response_pasid_use;
		logic stage2_exec_split_support;
		logic page_hw_attribute_support;
		logic hier_attr_disable_support;
		logic [15:0] stall_record_limit;
		logic [1:0] va_extend_field;
		logic granule_64kb_support;
		logic granule_16kb_support;
		logic granule_4kb_support;
		logic [2:0] output_addr_size;
		logic [31:0] impl_defined_word;
	} fid_cap_s;

	// neutral example build; the impl-defined word is arbitrary
	localparam fid_cap_s CAP_DEFAULT = '{
		command_queue_max_log2: 5'h08, event_queue_max_log2: 5'h07,
		page_request_queue_max_log2: 5'h06, substream_id_width: 5'h08,
		stream_id_width: 6'h10, virtual_translation_page_present: 1'b1, page_req_present: 1'b1,
		stage1_present: 1'b1, virtual_translation_page_base: 10'h001,
		break_make_level: 2'h1, range_invalidation_support: 1'b1,
		stage2_memtype_control: 1'b1, hier_attr_disable_support: 1'b1,
		stall_record_limit: 16'h0020, granule_64kb_support: 1'b1,
		granule_4kb_support: 1'b1, output_addr_size: 3'h5,
		impl_defined_word: 32'h0000_0000, default: '0};

	typedef struct packed {
		logic rsvd31;
		logic tables_preset;
		logic queues_preset;
		logic offset_style_base_flag;
		logic memtype_override_support;
		logic permission_override_support;
		logic [4:0] command_queue_max_log2;
		logic [4:0] event_queue_max_log2;
		logic [4:0] page_request_queue_max_log2;
		logic [4:0] substream_id_width;
		logic [5:0] stream_id_width;
	} fid_presets_sizes_s;

	typedef struct packed {
		logic [21:0] rsvd;
		logic [9:0] virtual_translation_page_base;
	} fid_virtual_translation_page_base_s;

	typedef struct packed {
		logic [18:0] rsvd_hi;
		logic [1:0] break_make_level;
		logic range_invalidation_support;
		logic small_table_support;
		logic stage2_memtype_control;
		logic partitioning_monitoring_support;
		logic rsvd6;
		logic overflow_response_pasid_use;
		logic stage2_exec_split_support;
		logic page_hw_attribute_support;
		logic hier_attr_disable_support;
		logic [1:0] rsvd_lo;
	} fid_extensions_s;

	typedef struct packed {
		logic [15:0] stall_record_limit;
		logic [3:0] rsvd_hi;
		logic [1:0] va_extend_field;
		logic [2:0] rsvd_mid;
		logic granule_64kb_support;
		logic granule_16kb_support;
		logic granule_4kb_support;
		logic rsvd3;
		logic [2:0] output_addr_size;
	} fid_granule_addr_s;

endpackage

// File: rtl/fid_queue_index.sv
// producer and consumer index pair of one queue, sized by its log2 entry count
`timescale 1ns/1ps
`default_nettype none
module fid_queue_index (
	input wire logic core_clk,
	input wire logic srst,
	input wire logic [4:0] size_log2,
	input wire logic wr_prod,
	input wire logic wr_cons,
	input wire logic [fid_pkg::IDX_W-1:0] wdata,
	output logic [fid_pkg::IDX_W-1:0] prod_q,
	output logic [fid_pkg::IDX_W-1:0] cons_q,
	output logic full,
	output logic empty
);
	logic [fid_pkg::IDX_W:0] span;
	logic [fid_pkg::IDX_W-1:0] mask;
	logic [fid_pkg::IDX_W-1:0] wrap_bit;
	logic [fid_pkg::IDX_W-1:0] diff;

	// n index bits plus one wrap bit above them
	assign span = (fid_pkg::IDX_W+1)'(1) << (size_log2 + 5'd1);
	assign mask = fid_pkg::IDX_W'(span - (fid_pkg::IDX_W+1)'(1));
	assign wrap_bit = fid_pkg::IDX_W'(1) << size_log2;
	assign diff = (prod_q ^ cons_q) & mask;
	assign empty = diff == '0;
	assign full = diff == wrap_bit;

	always_ff @(posedge core_clk) begin
		if (srst) begin
			prod_q <= fid_pkg::IDX_RST;
			cons_q <= fid_pkg::IDX_RST;
		end else begin
			// stale upper bits are dropped when the size shrinks
			prod_q <= (wr_prod ? wdata : prod_q) & mask;
			cons_q <= (wr_cons ? wdata : cons_q) & mask;
		end
	end
endmodule
`default_nettype wire

// File: rtl/fid_regs.sv
// feature identification register bank with avalon-mm slave
//
// Overview of operation
// - bit 30 flags fixed stream table bases
// - bit 29 flags fixed queue bases
// - bit 28 relative bases, zero without presets
// - bits 27/26 report attribute override support
// - command queue log2 size, at most 19
// - event queue log2 size, at most 19
// - page request queue log2 size, at most 19
// - queue index registers carry one wrap bit
// - substream id width 0 to 20
// - stream id width 0 to 32
// - translation page base, zero when absent
// - break-before-make level reads 01 or 10
// - range, small table, stage2 memtype flags
// - partitioning flag; unsupported fields read zero
// - overflow pasid flag needs page requests, substreams
// - bit 4 stage2 execute split support
// - page attributes imply hierarchical disable set
// - hierarchical disable zero without stage one
// - bits 31:16 stall record limit
// - va extend 48 or 52, 52 needs 64KB
// - granule bits; 4KB set with 32-bit format
// - output size codes, reserved and 52 guarded
//
// The Avalon-MM interface to the registers and the register addresses were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module fid_regs #(
	parameter fid_pkg::fid_cap_s CAP = fid_pkg::CAP_DEFAULT
) (
	input wire logic core_clk,
	input wire logic srst,
	input wire logic [7:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic [1:0] avs_response,
	output logic avs_waitrequest
);
	localparam int unsigned NQ = fid_pkg::NUM_QUEUES;

	fid_pkg::fid_presets_sizes_s id_ps;
	fid_pkg::fid_virtual_translation_page_base_s id_vb;
	fid_pkg::fid_extensions_s id_ex;
	fid_pkg::fid_granule_addr_s id_ga;

	logic stage1_ok;
	logic page_hw_attribute_support_ok;
	logic g64_ok;
	logic [1:0] break_make_level_raw;
	logic [2:0] oas_raw;
	logic [31:0] virtual_translation_page_page;

	function automatic logic [4:0] clamp5(input logic [4:0] v, input logic [4:0] lim);
		return (v > lim) ? lim : v;
	endfunction

	// capability words; every constraint is enforced here so a bad build cannot leak out
	assign id_ps.rsvd31 = 1'b0;
	assign id_ps.tables_preset = CAP.tables_preset;
	assign id_ps.queues_preset = CAP.queues_preset;
	assign id_ps.offset_style_base_flag = CAP.offset_style_base_flag
		& (CAP.tables_preset | CAP.queues_preset);
	assign id_ps.memtype_override_support = CAP.memtype_override_support;
	assign id_ps.permission_override_support = CAP.permission_override_support;
	assign id_ps.command_queue_max_log2 =
		clamp5(CAP.command_queue_max_log2, fid_pkg::QS_MAX);
	assign id_ps.event_queue_max_log2 =
		clamp5(CAP.event_queue_max_log2, fid_pkg::QS_MAX);
	assign id_ps.page_request_queue_max_log2 =
		clamp5(CAP.page_request_queue_max_log2, fid_pkg::QS_MAX);
	assign id_ps.substream_id_width =
		clamp5(CAP.substream_id_width, fid_pkg::SSID_MAX);
	assign id_ps.stream_id_width = (CAP.stream_id_width > fid_pkg::SID_MAX) ?
		fid_pkg::SID_MAX : CAP.stream_id_width;

	assign id_vb.rsvd = '0;
	assign id_vb.virtual_translation_page_base = CAP.virtual_translation_page_present ?
		CAP.virtual_translation_page_base : '0;
	// page address offset from the unit base, kept in a readable word
	assign virtual_translation_page_page = CAP.virtual_translation_page_present ? fid_pkg::VIRTUAL_TRANSLATION_PAGE_PAGE_ORIGIN
		+ 32'(id_vb.virtual_translation_page_base) * fid_pkg::VIRTUAL_TRANSLATION_PAGE_PAGE_UNIT
		: 32'h0000_0000;

	assign break_make_level_raw = CAP.break_make_level;
	assign stage1_ok = CAP.stage1_present;
	// page attributes are withdrawn without stage one so that both flags stay legal
	assign page_hw_attribute_support_ok = CAP.page_hw_attribute_support & stage1_ok;
	assign id_ex.rsvd_hi = '0;
	assign id_ex.break_make_level = (break_make_level_raw == fid_pkg::BREAK_MAKE_LEVEL_L2) ?
		fid_pkg::BREAK_MAKE_LEVEL_L2 : fid_pkg::BREAK_MAKE_LEVEL_L1;
	assign id_ex.range_invalidation_support = CAP.range_invalidation_support;
	assign id_ex.small_table_support = CAP.small_table_support;
	assign id_ex.stage2_memtype_control = CAP.stage2_memtype_control;
	// no partitioning registers exist in this bank, so nothing else to zero
	assign id_ex.partitioning_monitoring_support =
		CAP.partitioning_monitoring_support;
	assign id_ex.rsvd6 = 1'b0;
	assign id_ex.overflow_response_pasid_use = CAP.overflow_response_pasid_use
		& CAP.page_req_present & (id_ps.substream_id_width != 5'h00);
	assign id_ex.stage2_exec_split_support = CAP.stage2_exec_split_support;
	assign id_ex.page_hw_attribute_support = page_hw_attribute_support_ok;
	assign id_ex.hier_attr_disable_support = stage1_ok
		& (CAP.hier_attr_disable_support | page_hw_attribute_support_ok);
	assign id_ex.rsvd_lo = '0;

	assign g64_ok = CAP.granule_64kb_support;
	assign oas_raw = CAP.output_addr_size;
	assign id_ga.stall_record_limit = CAP.stall_record_limit;
	assign id_ga.rsvd_hi = '0;
	assign id_ga.va_extend_field = (CAP.va_extend_field == fid_pkg::VAX_52 && g64_ok) ?
		fid_pkg::VAX_52 : fid_pkg::VAX_48;
	assign id_ga.rsvd_mid = '0;
	assign id_ga.granule_64kb_support = g64_ok;
	assign id_ga.granule_16kb_support = CAP.granule_16kb_support;
	assign id_ga.granule_4kb_support = CAP.granule_4kb_support
		| CAP.fmt32_present;
	assign id_ga.rsvd3 = 1'b0;
	assign id_ga.output_addr_size =
		(oas_raw == fid_pkg::OAS_RSVD) ? (g64_ok ? fid_pkg::OAS_52 : fid_pkg::OAS_48) :
		(oas_raw == fid_pkg::OAS_52 && !g64_ok) ? fid_pkg::OAS_48 : oas_raw;

	// bus handshake: one wait cycle, then the request is taken
	logic ack_q;
	logic req;
	logic take_wr;
	logic first;
	logic [31:0] wmask;

	assign req = avs_read | avs_write;
	assign first = req & ~ack_q;
	assign avs_waitrequest = first;
	assign take_wr = avs_write & ack_q;
	assign wmask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
		{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};

	always_ff @(posedge core_clk) begin
		if (srst) begin
			ack_q <= 1'b0;
		end else begin
			ack_q <= first;
		end
	end

	// address decode
	logic hit_ps;
	logic hit_vb;
	logic hit_ex;
	logic hit_im;
	logic hit_ga;
	logic hit_vp;
	logic hit_id;
	logic hit_qcfg;
	logic hit_qstat;
	logic hit_wign;
	logic [NQ-1:0] hit_prod;
	logic [NQ-1:0] hit_cons;
	logic hit_any;

	assign hit_ps = avs_address == fid_pkg::OFS_PRESETS_SIZES;
	assign hit_vb = avs_address == fid_pkg::OFS_VIRTUAL_TRANSLATION_PAGE_BASE;
	assign hit_ex = avs_address == fid_pkg::OFS_EXTENSIONS;
	assign hit_im = avs_address == fid_pkg::OFS_IMPL_DEFINED;
	assign hit_ga = avs_address == fid_pkg::OFS_GRANULE_ADDR;
	assign hit_vp = avs_address == fid_pkg::OFS_VIRTUAL_TRANSLATION_PAGE_PAGE;
	assign hit_id = hit_ps | hit_vb | hit_ex | hit_im | hit_ga | hit_vp;
	assign hit_qcfg = avs_address == fid_pkg::OFS_QUEUE_CFG;
	assign hit_qstat = avs_address == fid_pkg::OFS_QUEUE_STAT;
	assign hit_wign = avs_address == fid_pkg::OFS_WR_IGNORED;
	assign hit_any = hit_id | hit_qcfg | hit_qstat | hit_wign
		| (|hit_prod) | (|hit_cons);

	// queue sizes in use, each bounded by its reported maximum
	logic [31:0] qcfg_q;
	logic [31:0] qcfg_wr;
	logic [4:0] qsize [NQ];
	logic [4:0] qmax [NQ];

	assign qmax[0] = id_ps.command_queue_max_log2;
	assign qmax[1] = id_ps.event_queue_max_log2;
	assign qmax[2] = id_ps.page_request_queue_max_log2;
	assign qcfg_wr = (qcfg_q & ~wmask) | (avs_writedata & wmask);

	logic [fid_pkg::IDX_W-1:0] prod [NQ];
	logic [fid_pkg::IDX_W-1:0] cons [NQ];
	logic [NQ-1:0] qfull;
	logic [NQ-1:0] qempty;
	logic [31:0] idx_rd [NQ+1];

	assign idx_rd[0] = 32'h0000_0000;

	genvar gi;
	generate
		for (gi = 0; gi < NQ; gi++) begin : g_queue
			logic [fid_pkg::IDX_W-1:0] widx;
			logic [7:0] prod_ofs;

			assign prod_ofs = fid_pkg::OFS_IDX_BASE + 8'(gi) * fid_pkg::OFS_IDX_STRIDE;
			assign hit_prod[gi] = avs_address == prod_ofs;
			assign hit_cons[gi] = avs_address == prod_ofs + fid_pkg::OFS_CONS_STEP;
			assign qsize[gi] = clamp5(qcfg_q[8*gi +: 5], qmax[gi]);
			assign widx = fid_pkg::IDX_W'(avs_writedata & wmask);
			assign idx_rd[gi+1] = idx_rd[gi]
				| (hit_prod[gi] ? 32'(prod[gi]) : 32'h0000_0000)
				| (hit_cons[gi] ? 32'(cons[gi]) : 32'h0000_0000);

			fid_queue_index u_idx (
				.core_clk(core_clk),
				.srst(srst),
				.size_log2(qsize[gi]),
				.wr_prod(take_wr & hit_prod[gi]),
				.wr_cons(take_wr & hit_cons[gi]),
				.wdata(widx),
				.prod_q(prod[gi]),
				.cons_q(cons[gi]),
				.full(qfull[gi]),
				.empty(qempty[gi])
			);
		end
	endgenerate

	always_ff @(posedge core_clk) begin
		if (srst) begin
			qcfg_q <= fid_pkg::QUEUE_CFG_RST;
		end else if (take_wr && hit_qcfg) begin
			qcfg_q <= qcfg_wr;
		end
	end

	// writes aimed at the identification words change nothing but this count
	logic [15:0] wign_q;
	logic wign_hit;

	assign wign_hit = take_wr & hit_id;

	always_ff @(posedge core_clk) begin
		if (srst) begin
			wign_q <= fid_pkg::WR_IGNORED_RST;
		end else if (wign_hit && wign_q != 16'hffff) begin
			wign_q <= wign_q + 16'h0001;
		end
	end

	// read path; sampled on the wait cycle so data stand at the taking edge
	logic [31:0] qcfg_rd;
	logic [31:0] qstat_rd;
	logic [31:0] rd_mux;
	logic [31:0] rdata_q;
	logic [1:0] rsp_q;

	assign qcfg_rd = {11'h000, qsize[2], 3'h0, qsize[1], 3'h0, qsize[0]};
	assign qstat_rd = {24'h00_0000, 1'b0, qfull, 1'b0, qempty};
	assign rd_mux =
		hit_ps ? id_ps :
		hit_vb ? id_vb :
		hit_ex ? id_ex :
		hit_im ? CAP.impl_defined_word :
		hit_ga ? id_ga :
		hit_vp ? virtual_translation_page_page :
		hit_qcfg ? qcfg_rd :
		hit_qstat ? qstat_rd :
		hit_wign ? {16'h0000, wign_q} :
		idx_rd[NQ];

	always_ff @(posedge core_clk) begin
		if (srst) begin
			rdata_q <= 32'h0000_0000;
			rsp_q <= fid_pkg::RSP_OKAY;
		end else if (first) begin
			rdata_q <= avs_read ? rd_mux : 32'h0000_0000;
			rsp_q <= hit_any ? fid_pkg::RSP_OKAY : fid_pkg::RSP_DECODEERROR;
		end
	end

	assign avs_readdata = rdata_q;
	assign avs_response = rsp_q;
endmodule
`default_nettype wire

// File: verification/fid_regs_properties.sv
// bus-side checker of the feature identification register bank
`timescale 1ns/1ps
`default_nettype none
module fid_regs_checker #(
	parameter fid_pkg::fid_cap_s CAP = fid_pkg::CAP_DEFAULT
) (
	input wire logic core_clk,
	input wire logic srst,
	input wire logic [7:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	input wire logic [31:0] avs_readdata,
	input wire logic [1:0] avs_response,
	input wire logic avs_waitrequest
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (srst);
	wire logic rd_done = avs_read & ~avs_waitrequest;
	wire logic rd_ps = rd_done & (avs_address == fid_pkg::OFS_PRESETS_SIZES);
	wire logic rd_ext = rd_done & (avs_address == fid_pkg::OFS_EXTENSIONS);
	wire logic rd_ga = rd_done & (avs_address == fid_pkg::OFS_GRANULE_ADDR);
	wire logic rd_pg = rd_done & (avs_address == fid_pkg::OFS_VIRTUAL_TRANSLATION_PAGE_PAGE);
	// page offset derived from the build, never from the bank itself
	wire logic [31:0] page_exp = CAP.virtual_translation_page_present ? fid_pkg::VIRTUAL_TRANSLATION_PAGE_PAGE_ORIGIN +
		{22'h0, CAP.virtual_translation_page_base} * fid_pkg::VIRTUAL_TRANSLATION_PAGE_PAGE_UNIT : 32'h0000_0000;

	chk_rel_preset: assert property (rd_ps && avs_readdata[28] |-> |avs_readdata[30:29])
		else $error("relative flag set without presets");
	chk_cmdq_max: assert property (rd_ps |-> avs_readdata[25:21] <= 5'd19)
		else $error("command queue size above limit");
	chk_evq_max: assert property (rd_ps |-> avs_readdata[20:16] <= 5'd19)
		else $error("event queue size above limit");
	chk_priq_max: assert property (rd_ps |-> avs_readdata[15:11] <= 5'd19)
		else $error("page request queue size above limit");
	chk_ssid_range: assert property (rd_ps |-> avs_readdata[10:6] <= 5'd20)
		else $error("substream width above limit");
	chk_sid_range: assert property (rd_ps |-> avs_readdata[5:0] <= 6'd32)
		else $error("stream width above limit");
	chk_page_offset: assert property (rd_pg |-> avs_readdata == page_exp)
		else $error("translation page offset wrong");
	chk_break_make_level_level: assert property (rd_ext |-> avs_readdata[12:11] inside {2'h1, 2'h2})
		else $error("break-make level not 1 or 2");
	chk_page_hw_attribute_support_had: assert property (rd_ext && avs_readdata[3] |-> avs_readdata[2])
		else $error("page attributes without hierarchical disable");
	chk_vax_code: assert property (rd_ga |-> avs_readdata[11:10] == 2'h0 ||
		(avs_readdata[11:10] == 2'h1 && avs_readdata[6]))
		else $error("va extend code illegal");
	chk_fmt_4kb: assert property (rd_ga && CAP.fmt32_present |-> avs_readdata[4])
		else $error("4KB granule clear with 32-bit format");
	chk_oas_code: assert property (rd_ga |-> avs_readdata[2:0] != 3'h7 &&
		(avs_readdata[2:0] != 3'h6 || avs_readdata[6]))
		else $error("output size code illegal");

	cov_read_ps: cover property (rd_ps);
	cov_ignored_wr: cover property (avs_write && !avs_waitrequest && avs_address == 8'h04);
	cov_decode_err: cover property (rd_done && avs_response == fid_pkg::RSP_DECODEERROR);
endmodule

bind fid_regs fid_regs_checker #(.CAP(CAP)) fid_regs_checker_i (
	.core_clk(core_clk),
	.srst(srst),
	.avs_address(avs_address),
	.avs_read(avs_read),
	.avs_write(avs_write),
	.avs_writedata(avs_writedata),
	.avs_byteenable(avs_byteenable),
	.avs_readdata(avs_readdata),
	.avs_response(avs_response),
	.avs_waitrequest(avs_waitrequest)
);
`default_nettype wire

// File: verification/test_fid_regs.sv
// self-checking bench of the feature identification register bank
`timescale 1ns/1ps
`default_nettype none
module test_fid_regs;
	// awkward build: out-of-range sizes and conflicting flags the bank must tidy
	localparam fid_pkg::fid_cap_s CAP_T = '{memtype_override_support: 1'b1,
		offset_style_base_flag: 1'b1, command_queue_max_log2: 5'h1f,
		event_queue_max_log2: 5'h13, page_request_queue_max_log2: 5'h05,
		substream_id_width: 5'h1f, stream_id_width: 6'h3f, stage1_present: 1'b1,
		fmt32_present: 1'b1, virtual_translation_page_base: 10'h3ff,
		break_make_level: 2'h2, range_invalidation_support: 1'b1,
		stage2_memtype_control: 1'b1, overflow_response_pasid_use: 1'b1,
		stage2_exec_split_support: 1'b1, page_hw_attribute_support: 1'b1,
		stall_record_limit: 16'h1234, va_extend_field: 2'h1, granule_16kb_support: 1'b1,
		output_addr_size: 3'h6, impl_defined_word: 32'h5a5a_0f0f, default: '0};
	logic core_clk, srst, avs_read, avs_write, avs_waitrequest;
	logic [7:0] avs_address;
	logic [31:0] avs_writedata, avs_readdata, d_s;
	logic [3:0] avs_byteenable;
	logic [1:0] avs_response, r_s;
	int error_cnt, n_compared;

	fid_regs #(.CAP(CAP_T)) fid_regs_i (
		.core_clk(core_clk),
		.srst(srst),
		.avs_address(avs_address),
		.avs_read(avs_read),
		.avs_write(avs_write),
		.avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata),
		.avs_response(avs_response),
		.avs_waitrequest(avs_waitrequest)
	);

	initial begin
		core_clk = 1'b0;
		forever #25 core_clk = ~core_clk;
	end

	task automatic conclude();
		$display("compared %0d, mismatches %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	task automatic chk(input string w, input logic [31:0] e, input logic [31:0] g);
		n_compared++;
		if (g !== e) begin
			error_cnt++;
			$display("BAD %s expected %h seen %h", w, e, g);
		end
	endtask

	// one bus transfer; readdata and response are taken at the accepting edge
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
		output logic [31:0] rd, output logic [1:0] rs);
		int n;
		@(posedge core_clk);
		avs_read <= ~wr;
		avs_write <= wr;
		avs_address <= a;
		avs_writedata <= wd;
		n = 0;
		// sampled right after the edge, so the values seen are those standing before it
		do begin
			@(posedge core_clk);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 50);
		if (avs_waitrequest !== 1'b0) begin
			error_cnt++;
			$display("BAD waitrequest expected 0 seen %b", avs_waitrequest);
			conclude();
		end
		rd = avs_readdata;
		rs = avs_response;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input string w,
		input logic [1:0] er = fid_pkg::RSP_OKAY);
		bus(1'b0, a, 32'h0000_0000, d_s, r_s);
		chk(w, e, d_s);
		chk({w, " response"}, {30'h0, er}, {30'h0, r_s});
	endtask

	task automatic test_id_words();
		rd_chk(fid_pkg::OFS_PRESETS_SIZES, 32'h0a73_2d20, "presets");
		rd_chk(fid_pkg::OFS_VIRTUAL_TRANSLATION_PAGE_BASE, 32'h0000_0000, "page base");
		rd_chk(fid_pkg::OFS_VIRTUAL_TRANSLATION_PAGE_PAGE, 32'h0000_0000, "page offset");
		rd_chk(fid_pkg::OFS_EXTENSIONS, 32'h0000_151c, "extensions");
		rd_chk(fid_pkg::OFS_IMPL_DEFINED, 32'h5a5a_0f0f, "impl word");
		rd_chk(fid_pkg::OFS_GRANULE_ADDR, 32'h1234_0035, "granules");
		$display("test id words done");
	endtask

	task automatic test_ro_writes();
		bus(1'b1, fid_pkg::OFS_PRESETS_SIZES, 32'hffff_ffff, d_s, r_s);
		chk("ignored write response", 32'h0, {30'h0, r_s});
		bus(1'b1, fid_pkg::OFS_EXTENSIONS, 32'h0000_0000, d_s, r_s);
		bus(1'b1, fid_pkg::OFS_GRANULE_ADDR, 32'hffff_ffff, d_s, r_s);
		rd_chk(fid_pkg::OFS_PRESETS_SIZES, 32'h0a73_2d20, "presets kept");
		rd_chk(fid_pkg::OFS_EXTENSIONS, 32'h0000_151c, "extensions kept");
		rd_chk(fid_pkg::OFS_GRANULE_ADDR, 32'h1234_0035, "granules kept");
		$display("test read-only writes done");
	endtask

	task automatic test_unmapped();
		rd_chk(8'h00, 32'h0000_0000, "unmapped read", fid_pkg::RSP_DECODEERROR);
		bus(1'b1, 8'h00, 32'hffff_ffff, d_s, r_s);
		chk("unmapped write response", 32'h3, {30'h0, r_s});
		// only the three writes to identification words are counted
		rd_chk(fid_pkg::OFS_WR_IGNORED, 32'h0000_0003, "ignored count");
		$display("test unmapped done");
	endtask

	task automatic test_queue_index();
		bus(1'b1, fid_pkg::OFS_QUEUE_CFG, 32'h001f_1f03, d_s, r_s);
		rd_chk(fid_pkg::OFS_QUEUE_CFG, 32'h0005_1303, "queue sizes");
		bus(1'b1, fid_pkg::OFS_IDX_BASE, 32'h000f_ffff, d_s, r_s);
		rd_chk(fid_pkg::OFS_IDX_BASE, 32'h0000_000f, "producer index");
		bus(1'b1, fid_pkg::OFS_IDX_BASE + fid_pkg::OFS_CONS_STEP, 32'h0000_0007, d_s, r_s);
		rd_chk(fid_pkg::OFS_IDX_BASE + fid_pkg::OFS_CONS_STEP, 32'h0000_0007, "consumer");
		// indices differ in the wrap bit only: command queue full, others empty
		rd_chk(fid_pkg::OFS_QUEUE_STAT, 32'h0000_0016, "queue status");
		// two lanes only: command queue shrinks to 4 entries, event queue to 16, page request lane keeps its size
		avs_byteenable <= 4'h3;
		bus(1'b1, fid_pkg::OFS_QUEUE_CFG, 32'hffff_0402, d_s, r_s);
		avs_byteenable <= 4'hf;
		rd_chk(fid_pkg::OFS_QUEUE_CFG, 32'h0005_0402, "lane write");
		rd_chk(fid_pkg::OFS_IDX_BASE, 32'h0000_0007, "truncated producer");
		rd_chk(fid_pkg::OFS_QUEUE_STAT, 32'h0000_0007, "status after shrink");
		$display("test queue index done");
	endtask

	task automatic test_reset();
		@(posedge core_clk);
		srst <= 1'b1;
		repeat (2) @(posedge core_clk);
		srst <= 1'b0;
		rd_chk(fid_pkg::OFS_QUEUE_CFG, 32'h0000_0000, "config after reset");
		rd_chk(fid_pkg::OFS_IDX_BASE, 32'h0000_0000, "producer after reset");
		rd_chk(fid_pkg::OFS_QUEUE_STAT, 32'h0000_0007, "status after reset");
		rd_chk(fid_pkg::OFS_WR_IGNORED, 32'h0000_0000, "count after reset");
		rd_chk(fid_pkg::OFS_PRESETS_SIZES, 32'h0a73_2d20, "presets after reset");
		$display("test reset done");
	endtask

	initial begin
		error_cnt = 0;
		n_compared = 0;
		srst = 1'b1;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_address = 8'h00;
		avs_writedata = 32'h0000_0000;
		avs_byteenable = 4'hf;
		repeat (16) @(posedge core_clk);
		srst <= 1'b0;
		test_id_words();
		test_ro_writes();
		test_unmapped();
		test_queue_index();
		test_reset();
		conclude();
	end
endmodule
`default_nettype wire
